// *** inc/pis_regs.svh ***
// Function
// - after reset every source is blocked until software sets global enable.
// - enabled qualifying edge raises a pending request; return acknowledge resumes main work.
// - each input has separate rise and fall events with distinct codes.
// - first eight inputs have a per-input function select; only edge mode interrupts.
// - input edge dispatch may be postponed by a delay in whole milliseconds.
// - delay comes from the delay register, loaded as the event leaves the pending queue.
// - three cyclic timer channels, each with its own disable flag.
// - timer channel period is 10 to 99 ms, independent of scan.
// - timers fire only after global enable; disable optional.
// - timer disable flags clear on run to stop transition.
// - six counter events share one common disable flag.
// - counter compare-set binds one counter and value to one event.
// - compare fires when counter value becomes equal, counting up or down.
// - shared counter disable flag clears on run to stop transition.
// - per-input edge disable flags clear on run to stop transition.
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH
`define PIS_CLK_HZ        125000000
`define PIS_MS_CYC        (`PIS_CLK_HZ / 1000)
`define PIS_MIN_US        10
`define PIS_MIN_CYC       ((`PIS_CLK_HZ / 1000000) * `PIS_MIN_US)
`define PIS_PER_MIN       7'd10
`define PIS_PER_MAX       7'd99
`define PIS_A_CTRL        12'h000
`define PIS_A_INDIS       12'h004
`define PIS_A_FUNC        12'h008
`define PIS_A_TPER0       12'h00c
`define PIS_A_TPER1       12'h010
`define PIS_A_TPER2       12'h014
`define PIS_A_DLY         12'h018
`define PIS_A_CMP0        12'h01c
`define PIS_A_CMPSEL      12'h020
`define PIS_A_STAT        12'h024
`define PIS_A_MASK        12'h028
`define PIS_A_CNT         12'h02c
`define PIS_A_EVENT       12'h030
`define PIS_B_GEN         0
`define PIS_B_RUN         1
`define PIS_B_TDIS        2
`define PIS_B_CDIS        5
`define PIS_B_ACK         6
`define PIS_ST_IN         0
`define PIS_ST_TMR        16
`define PIS_ST_CNT        19
`endif

// *** inc/pis_pkg.sv ***
package pis_pkg;
   typedef enum logic [2:0] {
      PIS_IDLE = 3'b001,
      PIS_WAIT = 3'b010,
      PIS_BUSY = 3'b100
   } pis_disp_type;
   typedef logic [7:0] pis_code_type;
endpackage

// *** inc/pis_evt_if.sv ***
`timescale 1ns/1ps
// events from the source logic to the dispatcher
interface pis_evt_if #(parameter int N = 8);
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface

// *** src/pis_edge_filter.sv ***
`timescale 1ns/1ps
`include "pis_regs.svh"
module pis_edge_filter #(
   parameter int N       = 8,
   parameter int MIN_CYC = `PIS_MIN_CYC
) (
   input  wire logic   clock,
   input  wire logic   srst,
   input  wire logic [N-1:0] pin,
   pis_evt_if.src      evt
);
   initial if (MIN_CYC < 1 || MIN_CYC > 65535) $error("bad MIN_CYC");
   logic [N-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [N-1:0] rise_q, fall_q;
   always_ff @(posedge clock) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   genvar i;
   for (i = 0; i < N; i++) begin : g_in
      logic [15:0] cnt_q;
      wire         agree = (s2_q[i] == s3_q[i]);
      wire         diff  = agree && (s3_q[i] != lvl_q[i]);
      wire         done  = diff && (cnt_q == 16'(MIN_CYC - 1));
      always_ff @(posedge clock) begin
         if (srst || !diff) begin
            cnt_q <= 16'h0000;
         end else if (!done) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
      always_ff @(posedge clock) begin
         if (srst) begin
            lvl_q[i]  <= 1'b0;
            rise_q[i] <= 1'b0;
            fall_q[i] <= 1'b0;
         end else begin
            rise_q[i] <= done && s3_q[i];
            fall_q[i] <= done && !s3_q[i];
            if (done) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end
   assign evt.rise = rise_q;
   assign evt.fall = fall_q;
endmodule

// *** src/pis_ms_timer.sv ***
`timescale 1ns/1ps
`include "pis_regs.svh"
// cyclic millisecond channel; period clamped to the legal window
module pis_ms_timer (
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       ms_tick,
   input  wire logic       run,
   input  wire logic [6:0] period,
   output logic            fire
);
   logic [6:0] cnt_q;
   logic       fire_q;
   wire  [6:0] per  = (period < `PIS_PER_MIN) ? `PIS_PER_MIN :
                      (period > `PIS_PER_MAX) ? `PIS_PER_MAX : period;
   wire        wrap = ms_tick && (cnt_q >= per - 7'd1);
   always_ff @(posedge clock) begin
      if (srst || !run) begin
         cnt_q  <= 7'h00;
         fire_q <= 1'b0;
      end else begin
         fire_q <= wrap;
         if (ms_tick) begin
            cnt_q <= wrap ? 7'h00 : cnt_q + 7'h01;
         end
      end
   end
   assign fire = fire_q;
endmodule

// *** src/pis_top.sv ***
`timescale 1ns/1ps
`include "pis_regs.svh"
module pis_top #(
   parameter int N_IN   = 8,
   parameter int MS_CYC = `PIS_MS_CYC,
   parameter int MIN_CYC = `PIS_MIN_CYC
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [N_IN-1:0] in_pin,
   input  wire logic [31:0] fast_counter_255,
   output logic             irq_request,
   output logic [7:0]       irq_code,
   output logic             irq
);
   initial if (N_IN != 8) $error("N_IN must be 8");
   initial if (MS_CYC < 2) $error("MS_CYC too small");

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic        gen_q, run_q, run_d1_q;
   logic [N_IN-1:0] in_dis_q, edge_mode_q;
   logic [2:0]  tdis_q;
   logic        cdis_q;
   logic [6:0]  tper_q [3];
   logic [15:0] dly_q;
   logic [31:0] cmp_q;
   logic [2:0]  cmp_sel_q;
   logic        cmp_arm_q;
   logic [24:0] stat_q, mask_q;
   logic [31:0] prdata_q;

   wire acc   = psel && penable;
   wire wr    = acc && pwrite;
   wire rd    = acc && !pwrite;
   wire a_ctl = (paddr == `PIS_A_CTRL);
   wire a_ind = (paddr == `PIS_A_INDIS);
   wire a_fn  = (paddr == `PIS_A_FUNC);
   wire a_tp0 = (paddr == `PIS_A_TPER0);
   wire a_tp1 = (paddr == `PIS_A_TPER1);
   wire a_tp2 = (paddr == `PIS_A_TPER2);
   wire a_dly = (paddr == `PIS_A_DLY);
   wire a_cmp = (paddr == `PIS_A_CMP0);
   wire a_cs  = (paddr == `PIS_A_CMPSEL);
   wire a_st  = (paddr == `PIS_A_STAT);
   wire a_mk  = (paddr == `PIS_A_MASK);
   wire a_cn  = (paddr == `PIS_A_CNT);
   wire a_ev  = (paddr == `PIS_A_EVENT);
   wire mapped = a_ctl | a_ind | a_fn | a_tp0 | a_tp1 | a_tp2 | a_dly | a_cmp
               | a_cs | a_st | a_mk | a_cn | a_ev;
   wire run_stop = run_d1_q && !run_q;
   wire ack      = wr && a_ctl && pwdata[`PIS_B_ACK];

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   always_ff @(posedge clock) begin
      if (srst) begin
         gen_q    <= 1'b0;
         run_q    <= 1'b0;
         run_d1_q <= 1'b0;
      end else begin
         run_d1_q <= run_q;
         if (wr && a_ctl) begin
            gen_q <= pwdata[`PIS_B_GEN];
            run_q <= pwdata[`PIS_B_RUN];
         end
      end
   end

   // disable flags cleared on run to stop
   always_ff @(posedge clock) begin
      if (srst || run_stop) begin
         in_dis_q <= '0;
         tdis_q   <= 3'h0;
         cdis_q   <= 1'b0;
      end else begin
         if (wr && a_ind) in_dis_q <= pwdata[N_IN-1:0];
         if (wr && a_ctl) begin
            tdis_q <= pwdata[`PIS_B_TDIS +: 3];
            cdis_q <= pwdata[`PIS_B_CDIS];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         edge_mode_q <= '0;
         tper_q[0]   <= `PIS_PER_MIN;
         tper_q[1]   <= `PIS_PER_MIN;
         tper_q[2]   <= `PIS_PER_MIN;
         dly_q       <= 16'h0000;
         cmp_q       <= 32'h0000_0000;
         cmp_sel_q   <= 3'h0;
         mask_q      <= '0;
      end else begin
         if (wr && a_fn)  edge_mode_q <= pwdata[N_IN-1:0];
         if (wr && a_tp0) tper_q[0] <= pwdata[6:0];
         if (wr && a_tp1) tper_q[1] <= pwdata[6:0];
         if (wr && a_tp2) tper_q[2] <= pwdata[6:0];
         if (wr && a_dly) dly_q <= pwdata[15:0];
         if (wr && a_cmp) cmp_q <= pwdata;
         if (wr && a_cs)  cmp_sel_q <= pwdata[2:0];
         if (wr && a_mk)  mask_q <= pwdata[24:0];
      end
   end

   // ------------------------------------------------------------
   // time base and sources
   // ------------------------------------------------------------
   logic [16:0] ms_q;
   wire         ms_tick = (ms_q == 17'(MS_CYC - 1));
   always_ff @(posedge clock) begin
      if (srst || ms_tick) ms_q <= 17'h00000;
      else ms_q <= ms_q + 17'h00001;
   end

   pis_evt_if #(.N(N_IN)) evt ();
   pis_edge_filter #(.N(N_IN), .MIN_CYC(MIN_CYC)) u_filt (
      .clock (clock),
      .srst  (srst),
      .pin   (in_pin),
      .evt   (evt.src)
   );

   logic [2:0] tfire;
   genvar t;
   for (t = 0; t < 3; t++) begin : g_tmr
      pis_ms_timer u_tmr (
         .clock   (clock),
         .srst    (srst),
         .ms_tick (ms_tick),
         .run     (gen_q && run_q),
         .period  (tper_q[t]),
         .fire    (tfire[t])
      );
   end

   // counter compare: equality reached from either side
   logic [31:0] cnt_prev_q;
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_prev_q <= 32'h0000_0000;
         cmp_arm_q  <= 1'b0;
      end else begin
         cnt_prev_q <= fast_counter_255;
         cmp_arm_q  <= (wr && a_cs) ? 1'b1 : cmp_arm_q;
      end
   end
   wire cmp_hit = cmp_arm_q && (fast_counter_255 == cmp_q)
                && (cnt_prev_q == cmp_q - 32'd1 || cnt_prev_q == cmp_q + 32'd1);
   wire cmp_ok  = cmp_sel_q < 3'd6;

   // ------------------------------------------------------------
   // status (rise 0..7, fall 8..15, timers 16..18, counters 19..24)
   // ------------------------------------------------------------
   wire [N_IN-1:0] in_ok = edge_mode_q & ~in_dis_q & {N_IN{gen_q && run_q}};
   wire [24:0] ev_set;
   assign ev_set[`PIS_ST_IN +: N_IN]        = evt.rise & in_ok;
   assign ev_set[`PIS_ST_IN + N_IN +: N_IN] = evt.fall & in_ok;
   assign ev_set[`PIS_ST_TMR +: 3]          = tfire & ~tdis_q;
   genvar c;
   for (c = 0; c < 6; c++) begin : g_cnt
      assign ev_set[`PIS_ST_CNT + c] = cmp_hit && cmp_ok && !cdis_q && gen_q
                                     && (cmp_sel_q == 3'(c));
   end

   wire [24:0] ev_all = ev_set;
   wire        st_rd  = rd && a_st;
   // a read clears only the bits it returned, so an event landing between
   // setup and access is not lost; set still wins over clear
   always_ff @(posedge clock) begin
      if (srst) stat_q <= '0;
      else stat_q <= (stat_q & ~(st_rd ? prdata_q[24:0] : 25'h0000000)) | ev_all;
   end
   assign irq = |(stat_q & mask_q);

   // ------------------------------------------------------------
   // dispatcher: pending queue, delay, routine in progress
   // ------------------------------------------------------------
   logic [24:0] pend_q;
   logic [15:0] dcnt_q;
   logic [7:0]  code_q;
   logic [4:0]  sel;
   logic        found;
   pis_pkg::pis_disp_type st_q;
   always_comb begin
      sel   = 5'h00;
      found = 1'b0;
      for (int k = 24; k >= 0; k--) begin
         if (pend_q[k]) begin
            sel   = 5'(k);
            found = 1'b1;
         end
      end
   end
   wire is_in   = sel < 5'(2 * N_IN);
   wire [7:0] code_n = (sel < 5'(N_IN)) ? {3'h0, sel[2:0], 2'b01} :
                       is_in ? {3'h0, sel[2:0], 2'b00} :
                       (sel < 5'd19) ? {3'h6, 5'(sel - 5'd16)} :
                       {3'h7, 5'(sel - 5'd18)};
   wire delay_done = (dcnt_q == 16'h0000);

   always_ff @(posedge clock) begin
      if (srst || !gen_q) begin
         pend_q <= '0;
         st_q   <= pis_pkg::PIS_IDLE;
         code_q <= 8'h00;
         dcnt_q <= 16'h0000;
      end else begin
         pend_q <= (pend_q & ~((st_q == pis_pkg::PIS_IDLE && found)
                  ? (25'h0000001 << sel) : 25'h0000000)) | ev_all;
         unique case (st_q)
            pis_pkg::PIS_IDLE: begin
               if (found) begin
                  code_q <= code_n;
                  dcnt_q <= is_in ? dly_q : 16'h0000;
                  st_q   <= pis_pkg::PIS_WAIT;
               end
            end
            pis_pkg::PIS_WAIT: begin
               if (delay_done) st_q <= pis_pkg::PIS_BUSY;
               else if (ms_tick) dcnt_q <= dcnt_q - 16'h0001;
            end
            pis_pkg::PIS_BUSY: begin
               if (ack) st_q <= pis_pkg::PIS_IDLE;
            end
         endcase
      end
   end
   assign irq_request = (st_q == pis_pkg::PIS_BUSY);
   assign irq_code    = code_q;

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   wire [31:0] rd_mux =
        a_ctl ? {25'h0, 1'b0, cdis_q, tdis_q, run_q, gen_q} :
        a_ind ? {24'h0, in_dis_q} :
        a_fn  ? {24'h0, edge_mode_q} :
        a_tp0 ? {25'h0, tper_q[0]} :
        a_tp1 ? {25'h0, tper_q[1]} :
        a_tp2 ? {25'h0, tper_q[2]} :
        a_dly ? {16'h0, dly_q} :
        a_cmp ? cmp_q :
        a_cs  ? {29'h0, cmp_sel_q} :
        a_st  ? {7'h0, stat_q} :
        a_mk  ? {7'h0, mask_q} :
        a_cn  ? cnt_prev_q :
        a_ev  ? {21'h0, st_q, code_q} : 32'h0000_0000;
   always_ff @(posedge clock) begin
      if (srst) prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) prdata_q <= rd_mux;
   end
   assign prdata = prdata_q;
endmodule

// *** verif/pis_far_model.sv ***
`timescale 1ns/1ps
// ------
// sensor terminals and fast counter
// ------
module pis_far_model (
   input  wire logic        clock,
   output logic [7:0]       in_pin,
   output logic [31:0]      fast_counter_255
);
   initial begin
      in_pin = 8'h00;
      fast_counter_255 = 32'h0000_0000;
   end
   // each level held 24 cycles so the width filter never eats it
   task automatic pulse(input int n);
      repeat (2) begin
         @(posedge clock);
         in_pin[n] <= ~in_pin[n];
         repeat (24) @(posedge clock);
      end
   endtask
   // one step a cycle through the compare value, either direction
   task automatic sweep(input int cmp, input bit up);
      for (int i = -4; i <= 4; i++) begin
         @(posedge clock);
         fast_counter_255 <= up ? 32'(cmp + i) : 32'(cmp - i);
      end
   endtask
endmodule

// *** verif/pis_properties.sv ***
`timescale 1ns/1ps
// ------
// port checks
// ------
module pis_properties (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        irq_request,
   input  wire logic [7:0]  irq_code,
   input  wire logic        irq
);
   wire access   = psel && penable;
   wire unmapped = paddr > 12'h030;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   chk_reset_quiet: assert property (disable iff (1'b0)
      srst |=> !irq && !irq_request && irq_code == 8'h00) else $error("reset left outputs set");
   chk_start_quiet: assert property ($fell(srst) |-> !irq [*2])
      else $error("irq right after reset");
   chk_ready_high: assert property (access |-> pready)
      else $error("access not answered");
   chk_err_unmapped: assert property (access && unmapped |-> pslverr && (pwrite || prdata == 0))
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (access && !unmapped && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   chk_err_phase: assert property (!access |-> !pslverr)
      else $error("error outside access");
   chk_err_pulse: assert property (pslverr |=> !pslverr)
      else $error("error held too long");
   chk_data_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
   cover property (access && unmapped);
   cover property ($rose(irq));
   cover property ($rose(irq_request));
endmodule
bind pis_top pis_properties u_chk (.clock, .srst, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .irq_request, .irq_code, .irq);

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "pis_regs.svh"
// ------
// bench
// ------
module tb;
   logic        clock;
   logic        srst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  in_pin;
   logic [31:0] fast_counter_255;
   logic        irq_request;
   logic [7:0]  irq_code;
   logic        irq;
   logic [31:0] q;
   logic        err;
   int          n_fail;
   int          checked;
   int          exp_stat;
   int          mask;
   int          n;
   int          cmp;
   pis_far_model u_far (.clock, .in_pin, .fast_counter_255);
   pis_top #(.N_IN(8), .MS_CYC(20), .MIN_CYC(2)) dut (.clock, .srst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .in_pin, .fast_counter_255, .irq_request,
      .irq_code, .irq);
   always #4 clock = ~clock;
   task automatic close_out();
      if (n_fail == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // irq level against the expected status and mask, then status; the read empties it
   task automatic see();
      @(negedge clock);
      chk({31'h0, irq}, {31'h0, (exp_stat & mask) != 0});
      @(posedge clock);
      rd(`PIS_A_STAT, exp_stat);
      exp_stat = 0;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      close_out();
   end
   initial begin
      clock = 1'b0;
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_fail = 0;
      checked = 0;
      exp_stat = 0;
      mask = 32'h1ff_ffff;
      void'($urandom(96591));
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      see();
      apb(1'b1, `PIS_A_FUNC, 32'hff);
      apb(1'b1, `PIS_A_MASK, mask);
      apb(1'b1, `PIS_A_CTRL, 32'h02);
      u_far.pulse(0);
      repeat (250) @(posedge clock);
      see();
      apb(1'b1, `PIS_A_CTRL, 32'h1f);
      n = $urandom % 8;
      u_far.pulse(n);
      exp_stat = (1 << n) | (1 << (n + 8));
      see();
      @(negedge clock);
      chk({31'h0, irq_request}, 32'h1);
      chk({24'h0, irq_code}, {27'h0, n[2:0], 2'b01});
      @(posedge clock);
      see();
      apb(1'b1, `PIS_A_CTRL, 32'h5f);
      @(negedge clock);
      chk({24'h0, irq_code}, {27'h0, n[2:0], 2'b00});
      @(posedge clock);
      apb(1'b1, `PIS_A_CTRL, 32'h5f);
      chk({31'h0, irq_request}, 32'h0);
      apb(1'b1, `PIS_A_DLY, 32'h4);
      apb(1'b1, `PIS_A_MASK, 32'h0);
      u_far.pulse(n);
      @(negedge clock);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, irq_request}, 32'h0);
      repeat (60) @(posedge clock);
      @(negedge clock);
      chk({31'h0, irq_request}, 32'h1);
      chk({24'h0, irq_code}, {27'h0, n[2:0], 2'b01});
      @(posedge clock);
      apb(1'b1, `PIS_A_MASK, mask);
      exp_stat = (1 << n) | (1 << (n + 8));
      see();
      apb(1'b1, `PIS_A_INDIS, 32'h1 << ((n + 1) % 8));
      u_far.pulse((n + 1) % 8);
      apb(1'b1, `PIS_A_INDIS, 32'h0);
      see();
      n = 10 + $urandom % 5;
      apb(1'b1, `PIS_A_TPER0, n);
      apb(1'b1, `PIS_A_CTRL, 32'h1b);
      repeat (n * 20 + 40) @(posedge clock);
      apb(1'b1, `PIS_A_CTRL, 32'h1f);
      exp_stat = 1 << `PIS_ST_TMR;
      see();
      for (int s = 0; s < 6; s++) begin
         cmp = 100 + $urandom % 5000;
         apb(1'b1, `PIS_A_CMP0, cmp);
         apb(1'b1, `PIS_A_CMPSEL, s);
         u_far.sweep(cmp, s[0]);
         exp_stat = 1 << (`PIS_ST_CNT + s);
         see();
      end
      apb(1'b1, `PIS_A_CTRL, 32'h3f);
      apb(1'b1, `PIS_A_CMPSEL, 32'h0);
      u_far.sweep(cmp, 1'b1);
      see();
      apb(1'b1, `PIS_A_INDIS, 32'hff);
      apb(1'b1, `PIS_A_CTRL, 32'h3d);
      rd(`PIS_A_CTRL, 32'h01);
      rd(`PIS_A_INDIS, 32'h0);
      apb(1'b1, 12'h040, 32'h5a);
      chk({31'h0, err}, 32'h1);
      rd(12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
      close_out();
   end
endmodule
